//--- verilog/sulbc_pkg.sv
// package: constants and types for the system unlock and boot config block
// Overview of operation
// RL1 - 32-bit read/write system key register, zero after power-on.
// RL2 - unlock only after key one then key two, written back to back.
// RL3 - any non-key write relocks; software may write 0x33333333.
// RL4 - unlock releases every protected register at once.
// RL5 - no time limit while unlocked; only key writes must be consecutive.
// RL6 - software should disable interrupts and dma before unlocking.
// RL7 - software should keep the unlocked interval short.
// RL8 - boot word is read-only, loaded at reset, unused bits read zero.
// RL9 - bit 31 set means untrusted: flash ignored, safe defaults used.
// RL10 - bit 29 reads one when the image is unsigned.
// RL11 - bit 28 reads one when code protection is enabled.
// RL12 - bit 3 one boots 32-bit set, zero boots compressed set.
// RL13 - debug-probe boots take the set from the debug select input.
// RL14 - bit 1 one routes all fetches to the instruction cache port.
// RL15 - code execution held off during the regulator power-up delay.
// RL16 - power-up delay applied on every resume, sleep included.
// RL17 - regulator brown-out sets reset status bit 1.
// RL18 - any other write between the key writes abandons the unlock.
// RL19 - locked after every reset.
package sulbc_pkg;
  localparam logic [11:0] SULBC_ADDR_BOOT_WORD = 12'h100;
  localparam logic [11:0] SULBC_ADDR_SYSTEM_KEY = 12'h010;
  localparam logic [11:0] SULBC_ADDR_STATUS = 12'h014;
  localparam logic [11:0] SULBC_ADDR_IRQ_STATUS = 12'h018;
  localparam logic [11:0] SULBC_ADDR_IRQ_MASK = 12'h01C;
  localparam logic [11:0] SULBC_ADDR_RESET_STATUS = 12'h020;
  localparam logic [31:0] SULBC_KEY_FIRST = 32'hAA996655;
  localparam logic [31:0] SULBC_KEY_SECOND = 32'h556699AA;
  localparam logic [31:0] SULBC_KEY_RESET = 32'h00000000;
  localparam int SULBC_BIT_UNTRUSTED = 31;
  localparam int SULBC_BIT_SIGN = 29;
  localparam int SULBC_BIT_PROTECT = 28;
  localparam int SULBC_BIT_ISA = 3;
  localparam int SULBC_BIT_SINGLE = 1;
  localparam int SULBC_BIT_BROWN_OUT = 1;
  // safe defaults when the flash word is untrusted: 32-bit set, split caches
  localparam logic SULBC_SAFE_ISA = 1'b1;
  localparam logic SULBC_SAFE_SINGLE = 1'b0;
  localparam logic SULBC_SAFE_SIGN = 1'b1;
  localparam logic SULBC_SAFE_PROTECT = 1'b0;
  localparam int SULBC_CLK_HZ = 20000000;
  localparam int SULBC_PU_DELAY_NS = 10000;
  localparam int SULBC_PU_CYCLES =
    (SULBC_PU_DELAY_NS * (SULBC_CLK_HZ / 1000000) + 999) / 1000;
  localparam int SULBC_IRQ_W = 3;
  localparam int SULBC_IRQ_UNLOCK = 0;
  localparam int SULBC_IRQ_RELOCK = 1;
  localparam int SULBC_IRQ_BROWN = 2;

  typedef enum logic [1:0] {
    SULBC_LOCKED = 2'b00,
    SULBC_ARMED = 2'b01,
    SULBC_OPEN = 2'b10
  } sulbc_lock_e;

  typedef enum logic [1:0] {
    SULBC_PU_WAIT = 2'b00,
    SULBC_PU_RUN = 2'b01
  } sulbc_pu_e;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sulbc_bus_s;

  typedef struct packed {
    logic untrusted;
    logic sign;
    logic protect;
    logic isa;
    logic single;
  } sulbc_cfg_s;
endpackage

//--- verilog/sulbc_top.sv
// module: system key unlock, boot word, power-up hold and brown-out flag
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
module sulbc_top #(
  parameter int PU_CYCLES = sulbc_pkg::SULBC_PU_CYCLES
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire sulbc_pkg::sulbc_bus_s bus_in,
  output logic [31:0] rdata_out,
  input wire sulbc_pkg::sulbc_cfg_s flash_cfg_in,
  input wire logic debug_probe_boot_in,
  input wire logic debug_boot_isa_select_in,
  input wire logic power_resume_in,
  input wire logic brown_out_reset_in,
  output logic unlocked_out,
  output logic exec_enable_out,
  output logic boot_isa_out,
  output logic program_cache_single_mode_out,
  output logic irq_out
);
  import sulbc_pkg::*;

  typedef struct packed {
    logic [31:0] key;
    sulbc_lock_e lock;
    sulbc_pu_e pu;
    logic [31:0] pu_cnt;
    sulbc_cfg_s cfg;
    logic [2:0] resume_sync;
    logic [2:0] brown_sync;
    logic brown_flag;
    logic [SULBC_IRQ_W-1:0] irq_stat;
    logic [SULBC_IRQ_W-1:0] irq_mask;
    logic [31:0] rdata;
  } sulbc_state_s;

  sulbc_state_s state_reg;
  sulbc_state_s state_next;
  logic resume_evt;
  logic brown_evt;
  logic [SULBC_IRQ_W-1:0] evt;
  logic [31:0] boot_word;

  // second and third stages both high make the event: a level, not an edge, counts
  assign resume_evt = state_reg.resume_sync[1] & state_reg.resume_sync[2]
    & ~state_reg.pu_cnt[31] & (state_reg.pu == SULBC_PU_RUN);
  assign brown_evt = state_reg.brown_sync[1] & state_reg.brown_sync[2];

  always_comb begin
    boot_word = 32'h00000000; // RL8
    boot_word[SULBC_BIT_UNTRUSTED] = state_reg.cfg.untrusted; // RL9
    boot_word[SULBC_BIT_SIGN] = state_reg.cfg.sign; // RL10
    boot_word[SULBC_BIT_PROTECT] = state_reg.cfg.protect; // RL11
    boot_word[SULBC_BIT_ISA] = state_reg.cfg.isa; // RL12
    boot_word[SULBC_BIT_SINGLE] = state_reg.cfg.single; // RL14
  end

  always_comb begin
    state_next = state_reg;
    evt = '0;
    state_next.resume_sync = {state_reg.resume_sync[1:0], power_resume_in};
    state_next.brown_sync = {state_reg.brown_sync[1:0], brown_out_reset_in};
    state_next.rdata = 32'h00000000;
    // key writes drive the lock machine; any other write breaks the pair
    // open state has no timeout, only a write moves the lock
    if (bus_in.wr) begin // RL5
      if (bus_in.addr == SULBC_ADDR_SYSTEM_KEY) begin
        state_next.key = bus_in.wdata; // RL1
        if (bus_in.wdata == SULBC_KEY_FIRST) begin
          state_next.lock = SULBC_ARMED; // RL2
        end else if (bus_in.wdata == SULBC_KEY_SECOND
                     && state_reg.lock == SULBC_ARMED) begin
          state_next.lock = SULBC_OPEN; // RL2
          evt[SULBC_IRQ_UNLOCK] = 1'b1;
        end else begin
          state_next.lock = SULBC_LOCKED; // RL3
        end
        // any key write that leaves the open state, key one included
        if (state_reg.lock == SULBC_OPEN
            && state_next.lock != SULBC_OPEN) begin
          evt[SULBC_IRQ_RELOCK] = 1'b1;
        end
      end else begin
        if (state_reg.lock == SULBC_ARMED) begin
          state_next.lock = SULBC_LOCKED; // RL18
        end
        if (bus_in.addr == SULBC_ADDR_IRQ_MASK) begin
          state_next.irq_mask = bus_in.wdata[SULBC_IRQ_W-1:0];
        end
      end
    end
    // power-up hold: execution waits out the regulator start-up
    case (state_reg.pu)
      SULBC_PU_WAIT: begin
        if (state_reg.pu_cnt >= 32'(PU_CYCLES - 1)) begin
          state_next.pu = SULBC_PU_RUN; // RL15
        end else begin
          state_next.pu_cnt = state_reg.pu_cnt + 32'h00000001;
        end
      end
      SULBC_PU_RUN: begin
        if (resume_evt) begin
          state_next.pu = SULBC_PU_WAIT; // RL16
          state_next.pu_cnt = 32'h00000000;
          state_next.pu_cnt[31] = 1'b0;
        end
      end
      default: begin
        state_next.pu = SULBC_PU_WAIT;
      end
    endcase
    if (brown_evt) begin
      state_next.brown_flag = 1'b1; // RL17
      evt[SULBC_IRQ_BROWN] = 1'b1;
    end
    if (bus_in.rd) begin
      case (bus_in.addr)
        SULBC_ADDR_BOOT_WORD: state_next.rdata = boot_word; // RL8
        SULBC_ADDR_SYSTEM_KEY: state_next.rdata = state_reg.key; // RL1
        SULBC_ADDR_STATUS: begin
          state_next.rdata[0] = (state_reg.lock == SULBC_OPEN);
          state_next.rdata[1] = (state_reg.pu == SULBC_PU_RUN);
        end
        SULBC_ADDR_IRQ_STATUS: begin
          state_next.rdata[SULBC_IRQ_W-1:0] = state_reg.irq_stat;
          state_next.irq_stat = '0;
        end
        SULBC_ADDR_IRQ_MASK: begin
          state_next.rdata[SULBC_IRQ_W-1:0] = state_reg.irq_mask;
        end
        SULBC_ADDR_RESET_STATUS: begin
          state_next.rdata[SULBC_BIT_BROWN_OUT] = state_reg.brown_flag;
          state_next.brown_flag = brown_evt;
        end
        default: state_next.rdata = 32'h00000000;
      endcase
    end
    // set wins over the read clear
    state_next.irq_stat = state_next.irq_stat | evt;
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_reg <= '0;
      state_reg.key <= SULBC_KEY_RESET; // RL1
      state_reg.lock <= SULBC_LOCKED; // RL19
      state_reg.pu <= SULBC_PU_WAIT; // RL15
      // reset load of the boot word; untrusted flash yields safe values
      if (flash_cfg_in.untrusted) begin
        state_reg.cfg.untrusted <= 1'b1; // RL9
        state_reg.cfg.sign <= SULBC_SAFE_SIGN;
        state_reg.cfg.protect <= SULBC_SAFE_PROTECT;
        state_reg.cfg.isa <= SULBC_SAFE_ISA;
        state_reg.cfg.single <= SULBC_SAFE_SINGLE;
      end else begin
        state_reg.cfg <= flash_cfg_in; // RL8
      end
    end else begin
      state_reg <= state_next;
    end
  end

  // one flag opens every guarded register together
  assign unlocked_out = (state_reg.lock == SULBC_OPEN); // RL4
  assign exec_enable_out = (state_reg.pu == SULBC_PU_RUN); // RL15
  assign boot_isa_out = debug_probe_boot_in ? debug_boot_isa_select_in
    : state_reg.cfg.isa; // RL13
  assign program_cache_single_mode_out = state_reg.cfg.single; // RL14
  assign rdata_out = state_reg.rdata;
  assign irq_out = |(state_reg.irq_stat & state_reg.irq_mask);
endmodule

//--- tb/sulbc_asserts.sv
// checker: port-level assertions for the unlock and boot word block
`timescale 1ns/1ns
module sulbc_asserts #(
  parameter int PU_CYCLES = sulbc_pkg::SULBC_PU_CYCLES
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire sulbc_pkg::sulbc_bus_s bus_in,
  input wire logic [31:0] rdata_out,
  input wire logic debug_probe_boot_in,
  input wire logic debug_boot_isa_select_in,
  input wire logic power_resume_in,
  input wire logic unlocked_out,
  input wire logic exec_enable_out,
  input wire logic boot_isa_out,
  input wire logic program_cache_single_mode_out
);
  import sulbc_pkg::*;
  localparam int PU_HI = PU_CYCLES + 2;
  logic kw, k1, k2, brd;
  assign kw = bus_in.wr && bus_in.addr == SULBC_ADDR_SYSTEM_KEY;
  assign k1 = kw && bus_in.wdata == SULBC_KEY_FIRST;
  assign k2 = kw && bus_in.wdata == SULBC_KEY_SECOND;
  assign brd = bus_in.rd && bus_in.addr == SULBC_ADDR_BOOT_WORD;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  AST_KEY_PAIR: assert property (k2 && $past(k1) |=> unlocked_out)
    else $error("key pair did not unlock");
  AST_RELOCK: assert property (kw && !k1 && !k2 |=> !unlocked_out)
    else $error("non-key write did not lock");
  AST_BROKEN: assert property (k2 && $past(bus_in.wr) && !$past(k1)
    |=> !unlocked_out)
    else $error("broken pair unlocked");
  AST_HOLD: assert property (!bus_in.wr |=> $stable(unlocked_out))
    else $error("lock state moved without a write");
  AST_RESET_LOCK: assert property ($fell(sys_rst_in)
    |-> !unlocked_out && !exec_enable_out)
    else $error("not locked and held after reset");
  AST_PU_DONE: assert property ($fell(sys_rst_in)
    |-> ##[1:PU_HI] exec_enable_out)
    else $error("execution not released after delay");
  AST_RESUME: assert property ($rose(power_resume_in)
    |-> ##[1:4] !exec_enable_out)
    else $error("resume did not hold execution");
  AST_BOOT_ZERO: assert property (brd
    |=> (rdata_out & 32'h4FFFFFF5) == 32'h0)
    else $error("unused boot word bits not zero");
  AST_SINGLE: assert property (brd
    |=> rdata_out[1] == program_cache_single_mode_out)
    else $error("cache mode output differs from boot word");
  AST_ISA_DBG: assert property (debug_probe_boot_in
    |-> boot_isa_out == debug_boot_isa_select_in)
    else $error("debug boot set not taken from select");
  AST_ISA_NORM: assert property (brd && !debug_probe_boot_in
    |=> rdata_out[3] == boot_isa_out)
    else $error("boot set differs from boot word");
endmodule
bind sulbc_top sulbc_asserts #(.PU_CYCLES(PU_CYCLES)) u_chk (.mclk_in,
  .sys_rst_in, .bus_in, .rdata_out, .debug_probe_boot_in,
  .debug_boot_isa_select_in, .power_resume_in, .unlocked_out,
  .exec_enable_out, .boot_isa_out, .program_cache_single_mode_out);

//--- tb/testbench.sv
// testbench: boot word table, unlock, interrupts, delay and brown-out
`timescale 1ns/1ns
module testbench;
  import sulbc_pkg::*;
  localparam int PU = 4;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  sulbc_bus_s bus_in = '0;
  sulbc_cfg_s flash_cfg_in = '0;
  logic debug_probe_boot_in = 1'b0;
  logic debug_boot_isa_select_in = 1'b0;
  logic power_resume_in = 1'b0;
  logic brown_out_reset_in = 1'b0;
  logic [31:0] rdata_out;
  logic unlocked_out, exec_enable_out, boot_isa_out, irq_out;
  logic program_cache_single_mode_out;
  int n_fail = 0;
  int checks_done = 0;
  // cfg {untrusted,sign,protect,isa,single} beside the boot word it gives
  logic [36:0] rows [4] = '{{5'h0F, 32'h3000000A}, {5'h0A, 32'h20000008},
    {5'h15, 32'hA0000008}, {5'h05, 32'h10000002}};
  always #25 mclk_in = ~mclk_in;
  sulbc_top #(.PU_CYCLES(PU)) dut (.mclk_in, .sys_rst_in, .bus_in,
    .rdata_out, .flash_cfg_in, .debug_probe_boot_in,
    .debug_boot_isa_select_in, .power_resume_in, .brown_out_reset_in,
    .unlocked_out, .exec_enable_out, .boot_isa_out,
    .program_cache_single_mode_out, .irq_out);
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one assignment per edge, so back-to-back requests never collide
  task automatic req(logic [11:0] a, logic [31:0] d, logic w, logic r);
    @(posedge mclk_in);
    bus_in <= '{a, d, w, r};
  endtask
  task automatic w(logic [11:0] a, logic [31:0] d);
    req(a, d, 1'b1, 1'b0);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] exp, string nm);
    req(a, 32'h0, 1'b0, 1'b1);
    req(12'h0, 32'h0, 1'b0, 1'b0);
    #1 chk(nm, rdata_out, exp);
  endtask
  task automatic rst(logic [4:0] c);
    @(posedge mclk_in);
    flash_cfg_in <= c;
    sys_rst_in <= 1'b1;
    repeat (10) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    #1 chk("exec", 32'(exec_enable_out), 32'h0);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic unlock;
    w(SULBC_ADDR_SYSTEM_KEY, SULBC_KEY_FIRST);
    w(SULBC_ADDR_SYSTEM_KEY, SULBC_KEY_SECOND);
  endtask
  initial begin
    #100000;
    n_fail++;
    wrap_up;
  end
  initial begin
    foreach (rows[i]) begin
      rst(rows[i][36:32]);
      rd(SULBC_ADDR_BOOT_WORD, rows[i][31:0], "boot");
      chk("isa", 32'(boot_isa_out), 32'(rows[i][3]));
      chk("single", 32'(program_cache_single_mode_out),
        32'(rows[i][1]));
    end
    repeat (PU) @(posedge mclk_in);
    #1 chk("exec up", 32'(exec_enable_out), 32'h1);
    w(SULBC_ADDR_BOOT_WORD, 32'hFFFFFFFF);
    rd(SULBC_ADDR_BOOT_WORD, 32'h10000002, "boot ro");
    rd(12'h0FC, 32'h0, "unmapped");
    rd(SULBC_ADDR_SYSTEM_KEY, 32'h0, "key reset");
    w(SULBC_ADDR_IRQ_MASK, 32'h7);
    rd(SULBC_ADDR_IRQ_MASK, 32'h7, "mask rw");
    unlock();
    rd(SULBC_ADDR_STATUS, 32'h3, "open");
    chk("irq", 32'(irq_out), 32'h1);
    rd(SULBC_ADDR_SYSTEM_KEY, SULBC_KEY_SECOND, "key rw");
    rd(SULBC_ADDR_IRQ_STATUS, 32'h1, "irq unlock");
    repeat (20) @(posedge mclk_in);
    #1 chk("irq clr", 32'(irq_out), 32'h0);
    chk("still open", 32'(unlocked_out), 32'h1);
    w(SULBC_ADDR_SYSTEM_KEY, 32'h33333333);
    rd(SULBC_ADDR_STATUS, 32'h2, "relock");
    rd(SULBC_ADDR_IRQ_STATUS, 32'h2, "irq relock");
    w(SULBC_ADDR_SYSTEM_KEY, SULBC_KEY_FIRST);
    w(SULBC_ADDR_IRQ_MASK, 32'h0);
    w(SULBC_ADDR_SYSTEM_KEY, SULBC_KEY_SECOND);
    rd(SULBC_ADDR_STATUS, 32'h2, "broken pair");
    @(posedge mclk_in);
    brown_out_reset_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    brown_out_reset_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1 chk("irq masked", 32'(irq_out), 32'h0);
    w(SULBC_ADDR_IRQ_MASK, 32'h4);
    rd(SULBC_ADDR_RESET_STATUS, 32'h2, "brown");
    chk("irq brown", 32'(irq_out), 32'h1);
    rd(SULBC_ADDR_RESET_STATUS, 32'h0, "brown clr");
    rd(SULBC_ADDR_IRQ_STATUS, 32'h4, "irq st brown");
    @(posedge mclk_in);
    power_resume_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    power_resume_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1 chk("resume hold", 32'(exec_enable_out), 32'h0);
    repeat (PU + 6) @(posedge mclk_in);
    #1 chk("resume run", 32'(exec_enable_out), 32'h1);
    for (int b = 0; b < 2; b++) begin
      @(posedge mclk_in);
      debug_probe_boot_in <= 1'b1;
      debug_boot_isa_select_in <= 1'(b);
      #1 chk("debug isa", 32'(boot_isa_out), 32'(b));
    end
    @(posedge mclk_in);
    debug_probe_boot_in <= 1'b0;
    unlock();
    rd(SULBC_ADDR_STATUS, 32'h3, "open again");
    rst(5'h00);
    chk("reset lock", 32'(unlocked_out), 32'h0);
    rd(SULBC_ADDR_SYSTEM_KEY, 32'h0, "key cleared");
    wrap_up;
  end
endmodule
